// ==== rtcs_pkg.sv ====
/*
 * Constants of the tuner control and status register bank: register addresses,
 * field positions, reset values and the timing of the IF counting window.
 * Assumes a 40 MHz system clock.
 */
`default_nettype none
package rtcs_pkg;
	localparam int unsigned RTCS_CLK_HZ = 40_000_000;

	localparam logic [3:0] RTCS_ADDR_TUNER_CONTROL = 4'h4;
	localparam logic [3:0] RTCS_ADDR_FOUND_FREQUENCY = 4'h5;
	localparam logic [3:0] RTCS_ADDR_TUNING_CHECK = 4'h6;

	localparam int RTCS_CTRL_WIDTH = 13;
	localparam logic [12:0] RTCS_CTRL_RESET = 13'h08B2;

	localparam int RTCS_BIT_SW_PORT_MODE = 12;
	localparam int RTCS_BIT_IF_COUNT_TIME_SEL = 11;
	localparam int RTCS_BIT_AUDIO_FORCE_MUTE = 10;
	localparam int RTCS_BIT_SOFT_MUTE_EN = 9;
	localparam int RTCS_BIT_STEREO_NOISE_CANCEL_EN = 8;
	localparam int RTCS_BIT_HARD_MUTE = 7;
	localparam int RTCS_BIT_SEARCH_LEVEL_HI = 6;
	localparam int RTCS_BIT_SEARCH_LEVEL_LO = 5;
	localparam int RTCS_BIT_INJECTION_SIDE_SEL = 4;
	localparam int RTCS_BIT_FORCED_MONO = 3;
	localparam int RTCS_BIT_SW_PORT_VALUE = 2;
	localparam int RTCS_BIT_DEEMPHASIS_SEL = 1;
	localparam int RTCS_BIT_SEARCH_STOP_ON_FAIL = 0;

	localparam int RTCS_FREQ_WIDTH = 14;
	localparam int RTCS_IF_COUNT_WIDTH = 7;
	localparam int RTCS_LEVEL_WIDTH = 4;
	localparam int RTCS_CHECK_WIDTH = 14;
	localparam int RTCS_CHECK_POS_IF_LO = 9;
	localparam int RTCS_CHECK_POS_TIMEOUT = 8;
	localparam int RTCS_CHECK_POS_LEVEL_LO = 4;
	localparam int RTCS_CHECK_POS_LOCK = 3;
	localparam int RTCS_CHECK_POS_STEREO = 2;

	// IF count window lengths in nanoseconds and in clock cycles.
	localparam longint unsigned RTCS_IF_TIME_LONG_NS = 15_625_000;
	localparam longint unsigned RTCS_IF_TIME_SHORT_NS = 2_020_000;
	localparam int unsigned RTCS_IF_CYC_LONG =
		int'((RTCS_IF_TIME_LONG_NS * RTCS_CLK_HZ) / 64'd1_000_000_000);
	localparam int unsigned RTCS_IF_CYC_SHORT =
		int'((RTCS_IF_TIME_SHORT_NS * RTCS_CLK_HZ) / 64'd1_000_000_000);
	localparam int RTCS_TIMER_WIDTH = 20;
endpackage
`default_nettype wire

// ==== rtcs_status_capture.sv ====
/*
 * Read-only status holder: loads a status word from the tuner core on a strobe.
 * Assumes the tuner core holds its status stable while the strobe is high.
 */
`timescale 1ns/1ps
`default_nettype none
module rtcs_status_capture #(
	parameter int WIDTH = 14
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_value,
	output logic [WIDTH-1:0] o_value
);
	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			o_value <= '0;
		else if (i_load)
			o_value <= i_value;
	end
endmodule
`default_nettype wire

// ==== rtcs_period_timer.sv ====
/*
 * One-shot counting window timer with two selectable lengths.
 * Assumes a start pulse from the tuner core; the length is latched at start.
 */
`timescale 1ns/1ps
`default_nettype none
module rtcs_period_timer
	import rtcs_pkg::*;
#(
	parameter int unsigned LONG_CYCLES = RTCS_IF_CYC_LONG,
	parameter int unsigned SHORT_CYCLES = RTCS_IF_CYC_SHORT
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_start,
	input wire logic i_long_sel,
	output logic o_busy,
	output logic o_done
);
	logic [RTCS_TIMER_WIDTH-1:0] count;
	wire [RTCS_TIMER_WIDTH-1:0] load_long = RTCS_TIMER_WIDTH'(LONG_CYCLES - 1);
	wire [RTCS_TIMER_WIDTH-1:0] load_short = RTCS_TIMER_WIDTH'(SHORT_CYCLES - 1);
	wire last = o_busy && (count == '0);

	// A start while busy restarts the window so a retune never sees a stale count.
	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			count <= '0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			o_done <= last && !i_start;
			if (i_start)
			begin
				count <= i_long_sel ? load_long : load_short;
				o_busy <= 1'b1;
			end
			else if (last)
				o_busy <= 1'b0;
			else if (o_busy)
				count <= count - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== rtcs_regs.sv ====
/*
 * Tuner control register bank: the low part of the tuner control register,
 * the found-frequency register and the tuning check register, with the
 * control outputs they steer and the IF counting window.
 * Assumes a serial front end (SPI or I2C) that turns host frames into
 * single-cycle register read and write strobes with a register address.
 */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - IF count time bit picks 15.625 ms when set, 2.02 ms when clear; resets set.
// - Force-mute or hard-mute mutes both audio channels; hard mute resets one.
// - Bit 8 enables stereo noise cancel, bit 9 soft mute; both reset off.
// - Injection bit selects high-side when set, low-side when clear; resets one.
// - De-emphasis bit selects 50 us when set, 75 us when clear; resets one.
// - Search-stop bit set halts search on failed IF count with good level.
// - Found frequency is a read-only 14-bit field at address 5.
// - Tuning check at address 6 holds IF count 15:9 and level 7:4.
// - Tuning check bit 8 reads one on PLL timeout, zero when settled.
// - Tuning check bit 3 reads one when PLL lock is detected.
// - Software port pin follows ready flag in port mode, else the port bit.
module rtcs_regs
	import rtcs_pkg::*;
#(
	parameter int unsigned IF_LONG_CYCLES = RTCS_IF_CYC_LONG,
	parameter int unsigned IF_SHORT_CYCLES = RTCS_IF_CYC_SHORT
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic [3:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [15:0] o_reg_rdata,
	input wire logic i_status_load,
	input wire logic [13:0] i_pll_found_freq,
	input wire logic [6:0] i_if_count,
	input wire logic i_tuning_timeout,
	input wire logic [3:0] i_level_count,
	input wire logic i_lock_detect,
	input wire logic i_pilot_detect,
	input wire logic i_tuner_ready_flag,
	input wire logic i_if_count_start,
	input wire logic i_search_active,
	input wire logic i_if_count_fail,
	input wire logic i_level_ok,
	output logic o_if_count_gate,
	output logic o_if_count_done,
	output logic o_search_halt,
	output logic o_audio_mute_left,
	output logic o_audio_mute_right,
	output logic o_soft_mute_en,
	output logic o_stereo_noise_cancel_en,
	output logic o_injection_high_side,
	output logic o_forced_mono,
	output logic o_deemphasis_50us,
	output logic [1:0] o_search_stop_level,
	output logic o_software_port_pin
);
	logic [RTCS_CTRL_WIDTH-1:0] tuner_control;
	logic [RTCS_FREQ_WIDTH-1:0] found_frequency;
	logic [RTCS_CHECK_WIDTH-1:0] tuning_check;
	logic search_halt;

	wire sel_ctrl = (i_reg_addr == RTCS_ADDR_TUNER_CONTROL);
	wire sel_freq = (i_reg_addr == RTCS_ADDR_FOUND_FREQUENCY);
	wire sel_check = (i_reg_addr == RTCS_ADDR_TUNING_CHECK);
	wire ctrl_wr = i_reg_wr && sel_ctrl;

	wire sw_port_mode = tuner_control[RTCS_BIT_SW_PORT_MODE];
	wire if_count_time_sel = tuner_control[RTCS_BIT_IF_COUNT_TIME_SEL];
	wire audio_force_mute = tuner_control[RTCS_BIT_AUDIO_FORCE_MUTE];
	wire hard_mute = tuner_control[RTCS_BIT_HARD_MUTE];
	wire sw_port_value = tuner_control[RTCS_BIT_SW_PORT_VALUE];
	wire search_stop_on_fail = tuner_control[RTCS_BIT_SEARCH_STOP_ON_FAIL];

	wire audio_mute = audio_force_mute || hard_mute;
	wire sw_port_next = sw_port_mode ? i_tuner_ready_flag : sw_port_value;

	// Packed status in the register's own bit order; the two unused low bits are added at readback.
	wire [RTCS_CHECK_WIDTH-1:0] check_in = {
		i_if_count,
		i_tuning_timeout,
		i_level_count,
		i_lock_detect,
		i_pilot_detect
	};

	wire [15:0] rd_ctrl = {3'b000, tuner_control};
	wire [15:0] rd_freq = {2'b00, found_frequency};
	wire [15:0] rd_check = {tuning_check, 2'b00};
	wire [15:0] rd_mux = sel_ctrl ? rd_ctrl :
		sel_freq ? rd_freq :
		sel_check ? rd_check : 16'h0000;

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			tuner_control <= RTCS_CTRL_RESET;
		else if (ctrl_wr)
			tuner_control <= i_reg_wdata[RTCS_CTRL_WIDTH-1:0];
	end

	// Only the control address is writable; the status holders load solely from the tuner core.
	rtcs_status_capture #(
		.WIDTH(RTCS_FREQ_WIDTH)
	) u_freq (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_load(i_status_load),
		.i_value(i_pll_found_freq),
		.o_value(found_frequency)
	);

	rtcs_status_capture #(
		.WIDTH(RTCS_CHECK_WIDTH)
	) u_check (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_load(i_status_load),
		.i_value(check_in),
		.o_value(tuning_check)
	);

	rtcs_period_timer #(
		.LONG_CYCLES(IF_LONG_CYCLES),
		.SHORT_CYCLES(IF_SHORT_CYCLES)
	) u_if_timer (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_start(i_if_count_start),
		.i_long_sel(if_count_time_sel),
		.o_busy(o_if_count_gate),
		.o_done(o_if_count_done)
	);

	// The halt decision is taken only at the end of a counting window, when the IF verdict is final.
	wire halt_now = search_stop_on_fail && i_search_active && o_if_count_done
		&& i_if_count_fail && i_level_ok;

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
		begin
			o_reg_rdata <= 16'h0000;
			search_halt <= 1'b0;
			o_audio_mute_left <= 1'b1;
			o_audio_mute_right <= 1'b1;
			o_software_port_pin <= 1'b0;
		end
		else
		begin
			if (i_reg_rd)
				o_reg_rdata <= rd_mux;
			search_halt <= halt_now;
			o_audio_mute_left <= audio_mute;
			o_audio_mute_right <= audio_mute;
			o_software_port_pin <= sw_port_next;
		end
	end

	assign o_search_halt = search_halt;
	assign o_soft_mute_en = tuner_control[RTCS_BIT_SOFT_MUTE_EN];
	assign o_stereo_noise_cancel_en = tuner_control[RTCS_BIT_STEREO_NOISE_CANCEL_EN];
	assign o_injection_high_side = tuner_control[RTCS_BIT_INJECTION_SIDE_SEL];
	assign o_forced_mono = tuner_control[RTCS_BIT_FORCED_MONO];
	assign o_deemphasis_50us = tuner_control[RTCS_BIT_DEEMPHASIS_SEL];
	assign o_search_stop_level = tuner_control[RTCS_BIT_SEARCH_LEVEL_HI:RTCS_BIT_SEARCH_LEVEL_LO];
endmodule
`default_nettype wire

// ==== rtcs_monitor.sv ====
/* Port checker of the tuner control bank.
 * Assumes it is bound onto rtcs_regs and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module rtcs_monitor (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic [3:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic i_reg_rd,
	input wire logic [15:0] o_reg_rdata,
	input wire logic i_if_count_start,
	input wire logic o_if_count_gate,
	input wire logic o_if_count_done,
	input wire logic o_search_halt,
	input wire logic o_audio_mute_left,
	input wire logic o_audio_mute_right,
	input wire logic o_stereo_noise_cancel_en,
	input wire logic o_injection_high_side
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_srst);
	wire w4 = i_reg_wr && i_reg_addr == 4'h4;
	a_mute_pair: assert property (o_audio_mute_left == o_audio_mute_right) else $error("mute pair");
	a_mute_cause: assert property (w4 |=> ##1 (o_audio_mute_left ==
		($past(i_reg_wdata[10], 2) | $past(i_reg_wdata[7], 2)))) else $error("mute cause");
	a_snc_write: assert property (w4 |=> o_stereo_noise_cancel_en == $past(i_reg_wdata[8])) else $error("snc");
	a_inj_write: assert property (w4 |=> o_injection_high_side == $past(i_reg_wdata[4])) else $error("inj");
	a_gate_start: assert property (i_if_count_start |=> o_if_count_gate) else $error("gate");
	a_done_end: assert property ($fell(o_if_count_gate) |-> o_if_count_done) else $error("done");
	a_halt_done: assert property (o_search_halt |-> $past(o_if_count_done)) else $error("halt");
	a_freq_upper: assert property (i_reg_rd && i_reg_addr == 4'h5 |=> o_reg_rdata[15:14] == 2'h0)
		else $error("freq");
	cover property (o_search_halt);
	cover property (o_if_count_done);
	cover property (w4 && i_reg_wdata[10]);
endmodule
bind rtcs_regs rtcs_monitor mon_u (
	.i_mclk(i_mclk),
	.i_srst(i_srst),
	.i_reg_addr(i_reg_addr),
	.i_reg_wr(i_reg_wr),
	.i_reg_wdata(i_reg_wdata),
	.i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata),
	.i_if_count_start(i_if_count_start),
	.o_if_count_gate(o_if_count_gate),
	.o_if_count_done(o_if_count_done),
	.o_search_halt(o_search_halt),
	.o_audio_mute_left(o_audio_mute_left),
	.o_audio_mute_right(o_audio_mute_right),
	.o_stereo_noise_cancel_en(o_stereo_noise_cancel_en),
	.o_injection_high_side(o_injection_high_side)
);
`default_nettype wire

// ==== rtcs_host.sv ====
/* Host model issuing register strobes at the falling edge.
 * Assumes read data one cycle after the read strobe. */
`timescale 1ns/1ps
`default_nettype none
module rtcs_host (
	input wire logic i_mclk,
	input wire logic [15:0] i_rdata,
	output logic [3:0] o_addr,
	output logic o_wr,
	output logic o_rd,
	output logic [15:0] o_wdata
);
	initial {o_addr, o_wr, o_rd, o_wdata} = 22'h0;
	task automatic acc(input logic [3:0] a, input logic w, input logic [15:0] d, output logic [15:0] q);
		@(negedge i_mclk);
		{o_addr, o_wr, o_rd, o_wdata} = {a, w, !w, d};
		@(negedge i_mclk);
		q = i_rdata;
		// Released address and data lines carry the inverse and both strobes drop, so a stale value cannot pass for a request.
		{o_addr, o_wr, o_rd, o_wdata} = {~a, 2'b00, ~d};
	endtask
endmodule
`default_nettype wire

// ==== rtcs_regs_test.sv ====
/* Self-checking bench of the tuner control bank.
 * Assumes the host model and shortened IF windows. */
`timescale 1ns/1ps
`default_nettype none
module rtcs_regs_test;
	logic i_mclk = 0, i_srst = 1, wr, rd, load = 0, ready = 0, start = 0, act = 0, fail = 0, lok = 0;
	logic [3:0] addr, lev = 0;
	logic [15:0] wdata, rdata, q;
	logic [13:0] freq = 0;
	logic [6:0] ifc = 0;
	logic to = 0, ld = 0, pil = 0;
	logic gate, done, halt, ml, mr, sm, stereo_noise_cancel_en, inj, mono, dee, pin;
	logic [1:0] lvl;
	int mismatches = 0, checked = 0, cycles = 0;
	rtcs_regs #(.IF_LONG_CYCLES(20), .IF_SHORT_CYCLES(5)) dut_u (.i_mclk, .i_srst, .i_reg_addr(addr),
		.i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_status_load(load),
		.i_pll_found_freq(freq), .i_if_count(ifc), .i_tuning_timeout(to), .i_level_count(lev),
		.i_lock_detect(ld), .i_pilot_detect(pil), .i_tuner_ready_flag(ready), .i_if_count_start(start),
		.i_search_active(act), .i_if_count_fail(fail), .i_level_ok(lok), .o_if_count_gate(gate),
		.o_if_count_done(done), .o_search_halt(halt), .o_audio_mute_left(ml), .o_audio_mute_right(mr),
		.o_soft_mute_en(sm), .o_stereo_noise_cancel_en(stereo_noise_cancel_en), .o_injection_high_side(inj),
		.o_forced_mono(mono), .o_deemphasis_50us(dee), .o_search_stop_level(lvl), .o_software_port_pin(pin));
	rtcs_host host_u (.i_mclk, .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
	initial forever #12.5 i_mclk = ~i_mclk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		if (mismatches == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			$display("Error at %0t: timeout", $time);
			finish_test;
		end
	end
	task automatic t_reset;
		host_u.acc(4'h4, 0, 0, q);
		chk(q, 16'h08B2);
		chk({ml, mr, sm, stereo_noise_cancel_en, inj, dee, pin}, 7'h66);
		chk(lvl, 2'b01);
	endtask
	task automatic t_ctrl;
		logic [15:0] v[5] = '{16'h0400, 16'h0080, 16'hFFFF, 16'h0316, 16'h0000};
		foreach (v[i])
		begin
			host_u.acc(4'h4, 1, v[i], q);
			@(negedge i_mclk);
			chk({ml, mr}, {2{v[i][10] | v[i][7]}});
			chk({sm, stereo_noise_cancel_en, inj, mono, dee}, {v[i][9], v[i][8], v[i][4], v[i][3], v[i][1]});
			chk(lvl, v[i][6:5]);
			host_u.acc(4'h4, 0, 0, q);
			chk(q, v[i] & 16'h1FFF);
		end
	endtask
	task automatic t_port;
		host_u.acc(4'h4, 1, 16'h0004, q);
		repeat (2) @(negedge i_mclk);
		chk(pin, 1);
		host_u.acc(4'h4, 1, 16'h1000, q);
		ready = 1;
		repeat (2) @(negedge i_mclk);
		chk(pin, 1);
		ready = 0;
		repeat (2) @(negedge i_mclk);
		chk(pin, 0);
	endtask
	task automatic t_stat;
		{freq, ifc, to, lev, ld} = {14'h2ABC, 7'h5A, 1'b1, 4'hC, 1'b1};
		load = 1;
		@(negedge i_mclk);
		load = 0;
		host_u.acc(4'h5, 1, 16'hFFFF, q);
		host_u.acc(4'h6, 1, 16'h0000, q);
		host_u.acc(4'h5, 0, 0, q);
		chk(q, 16'h2ABC);
		host_u.acc(4'h6, 0, 0, q);
		chk(q, 16'hB5C8);
		host_u.acc(4'h9, 0, 0, q);
		chk(q, 16'h0000);
	endtask
	task automatic t_win(input logic [15:0] c, input int n, input int h);
		int g = 0, d = 0, s = 0;
		host_u.acc(4'h4, 1, c, q);
		{act, fail, lok, start} = 4'hF;
		@(negedge i_mclk);
		start = 0;
		repeat (n + 8)
		begin
			g += gate;
			d += done;
			s += halt;
			@(negedge i_mclk);
		end
		chk(g, n);
		chk(d, 1);
		chk(s, h);
	endtask
	initial
	begin
		repeat (6) @(negedge i_mclk);
		i_srst = 0;
		t_reset;
		t_ctrl;
		t_port;
		t_stat;
		t_win(16'h0801, 20, 1);
		t_win(16'h0000, 5, 0);
		finish_test;
	end
endmodule
`default_nettype wire
